/* design/sram_host_ctrl.sv */
// Host-side sequencer for an asynchronous 32-bit SRAM with byte lanes.
// Assumes one request at a time from the user side and that the memory
// meets its own float and access limits on the shared data pins.
`timescale 1ns/1ps
// Function
// - Read: select low, lanes low, gate low, strobe high, enable high.
// - Lower the output gate one cycle after address and controls.
// - Address pins change only from a register, never glitching.
// - Frame accesses by chip select or by chip enable, chosen per access.
// - Address is stable no later than the enabling select edge.
// - Read access and read cycle last at least 22 ns.
// - Strobe low at least 7 ns; select and enable 10 ns to write end.
// - Write data set up 6 ns before write end, held past it.
// - Address valid at write start, 12 ns before its end, held after.
// - Strobe stays high at least 5 ns between write pulses.
// - Writes repeat no faster than 12 ns.
// - Lane pulse at least 8 ns with data valid 8 ns before its end.
// - Write: strobe, select and chosen lanes low with enable high.
module sram_host_ctrl (
    // Clock and reset
    input  wire logic                               mclk,
    input  wire logic                               sys_rst,
    // Framing choice
    input  wire logic                               frameWithEnable,
    // Request
    input  wire logic                               reqValid,
    output logic                                    reqReady,
    input  wire logic                               reqWrite,
    input  wire logic [sram_host_pkg::ADDR_W-1:0]   reqAddr,
    input  wire logic [sram_host_pkg::DATA_W-1:0]   reqWdata,
    input  wire logic [sram_host_pkg::LANES-1:0]    reqLanes,
    // Answer
    output logic                                    rspValid,
    output logic [sram_host_pkg::DATA_W-1:0]        rspRdata,
    // Memory control pins
    output logic [sram_host_pkg::ADDR_W-1:0]        sramAddr,
    output logic                                    chipSelectLow,
    output logic                                    chipEnable,
    output logic                                    writeStrobeLow,
    output logic                                    outputGateLow,
    output logic [sram_host_pkg::LANES-1:0]         byteLaneEnableLow,
    // Memory data pins
    input  wire logic [sram_host_pkg::DATA_W-1:0]   dataIn,
    output logic [sram_host_pkg::DATA_W-1:0]        dataOut,
    output logic                                    dataOeLow
);
    import sram_host_pkg::*;

    typedef enum logic [1:0] {
        IDLE,
        RD_ACCESS,
        WR_PULSE,
        WR_RECOVER
    } phase_t;

    typedef struct packed {
        phase_t            phase;
        logic              enFrame;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  laneLow;
        logic              csLow;
        logic              ce;
        logic              weLow;
        logic              oeLow;
        logic              rspValid;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{
        phase:    IDLE,
        enFrame:  1'b0,
        addr:     ADDR_RESET,
        laneLow:  LANES_OFF,
        csLow:    1'b1,
        ce:       1'b1,
        weLow:    1'b1,
        oeLow:    1'b1,
        rspValid: 1'b0
    };

    ctrl_t ctrl_reg;
    ctrl_t ctrl_next;

    logic               timerLoad;
    logic [TIMER_W-1:0] timerValue;
    logic               timerExpired;
    logic               driveStart;
    logic               driveStop;
    logic               capture;
    logic               selActive;
    logic               laneActive;

    // Level of the framing pin that is not pulsed: select stays low and
    // enable idles low when enable frames, the reverse when select frames.
    function automatic logic idle_level(input logic enFrame);
        return ~enFrame;
    endfunction

    always_comb
    begin
        ctrl_next          = ctrl_reg;
        ctrl_next.rspValid = 1'b0;
        timerLoad          = 1'b0;
        timerValue         = READ_LOAD;
        driveStart         = 1'b0;
        driveStop          = 1'b0;
        capture            = 1'b0;
        case (ctrl_reg.phase)
            IDLE:
            begin
                if (reqValid)
                begin
                    ctrl_next.enFrame = frameWithEnable;
                    ctrl_next.addr    = reqAddr;
                    ctrl_next.laneLow = ~reqLanes;
                    ctrl_next.csLow   = 1'b0;
                    ctrl_next.ce      = 1'b1;
                    timerLoad         = 1'b1;
                    if (reqWrite)
                    begin
                        ctrl_next.weLow = 1'b0;
                        driveStart      = 1'b1;
                        timerValue      = WRITE_LOAD;
                        ctrl_next.phase = WR_PULSE;
                    end
                    else
                    begin
                        timerValue      = READ_LOAD;
                        ctrl_next.phase = RD_ACCESS;
                    end
                end
            end
            RD_ACCESS:
            begin
                ctrl_next.oeLow = 1'b0;
                if (timerExpired)
                begin
                    capture            = 1'b1;
                    ctrl_next.oeLow    = 1'b1;
                    ctrl_next.csLow    = idle_level(ctrl_reg.enFrame);
                    ctrl_next.ce       = idle_level(ctrl_reg.enFrame);
                    ctrl_next.laneLow  = LANES_OFF;
                    ctrl_next.rspValid = 1'b1;
                    ctrl_next.phase    = IDLE;
                end
            end
            WR_PULSE:
            begin
                if (timerExpired)
                begin
                    ctrl_next.weLow   = 1'b1;
                    ctrl_next.csLow   = idle_level(ctrl_reg.enFrame);
                    ctrl_next.ce      = idle_level(ctrl_reg.enFrame);
                    ctrl_next.laneLow = LANES_OFF;
                    timerLoad         = 1'b1;
                    timerValue        = RECOVERY_LOAD;
                    ctrl_next.phase   = WR_RECOVER;
                end
            end
            WR_RECOVER:
            begin
                // Data held after.
                // Data keeps driving here, which gives hold after the
                // terminating edge at the cost of one cycle per write.
                if (timerExpired)
                begin
                    driveStop          = 1'b1;
                    ctrl_next.rspValid = 1'b1;
                    ctrl_next.phase    = IDLE;
                end
            end
            default:
            begin
                ctrl_next = CTRL_RESET;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_reg <= CTRL_RESET;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
        end
    end

    sram_op_timer u_timer (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .load      (timerLoad),
        .loadValue (timerValue),
        .expired   (timerExpired)
    );

    sram_data_port u_data (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .driveStart   (driveStart),
        .driveStop    (driveStop),
        .capture      (capture),
        .captureLanes (~ctrl_reg.laneLow),
        .wrData       (reqWdata),
        .rdData       (rspRdata),
        .pinDataIn    (dataIn),
        .pinDataOut   (dataOut),
        .pinDataOeLow (dataOeLow)
    );

    assign reqReady          = (ctrl_reg.phase == IDLE);
    assign rspValid          = ctrl_reg.rspValid;
    assign sramAddr          = ctrl_reg.addr;
    assign chipSelectLow     = ctrl_reg.csLow;
    assign chipEnable        = ctrl_reg.ce;
    assign writeStrobeLow    = ctrl_reg.weLow;
    assign outputGateLow     = ctrl_reg.oeLow;
    assign byteLaneEnableLow = ctrl_reg.laneLow;

    assign selActive  = ~chipSelectLow & chipEnable;
    assign laneActive = (byteLaneEnableLow != LANES_OFF);

    a_read_controls: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !outputGateLow |-> !chipSelectLow && chipEnable && writeStrobeLow)
        else $error("Read gate low without read controls.");

    a_gate_delay: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $fell(outputGateLow) |-> $past(selActive) && writeStrobeLow)
        else $error("Output gate fell before select was active.");

    a_addr_change: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $changed(sramAddr) |-> $rose(selActive))
        else $error("Address changed outside an access start.");

    a_frame_style: assert property (
        @(posedge mclk) disable iff (sys_rst)
        ctrl_reg.enFrame ? !chipSelectLow : chipEnable)
        else $error("Idle framing pin moved.");

    a_read_access: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $rose(selActive) && writeStrobeLow
            |-> selActive[*3] ##1 (!selActive && rspValid))
        else $error("Read access shorter or longer than three cycles.");

    a_wr_pulse: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $fell(writeStrobeLow)
            |-> (!writeStrobeLow && selActive)[*2] ##1 writeStrobeLow)
        else $error("Write pulse not two cycles with select.");

    a_wr_data: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !writeStrobeLow |-> !dataOeLow ##1 (!dataOeLow && $stable(dataOut)))
        else $error("Write data not held across the pulse.");

    a_addr_hold: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !writeStrobeLow |=> $stable(sramAddr))
        else $error("Address moved during or at end of write.");

    a_wr_recovery: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $rose(writeStrobeLow) |-> writeStrobeLow[*2])
        else $error("Write strobe high time too short.");

    a_lane_pulse: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $rose(laneActive) |-> laneActive[*2])
        else $error("Lane enable pulse shorter than two cycles.");

    a_wr_controls: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !writeStrobeLow |-> !chipSelectLow && chipEnable && outputGateLow)
        else $error("Write strobe low without write controls.");

    a_bus_turn: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !dataOeLow |-> outputGateLow && $past(outputGateLow))
        else $error("Host drives data while memory may drive.");

endmodule

/* shared/sram_host_pkg.sv */
// Constants for the host-side controller of an asynchronous 32-bit SRAM.
// Assumes a single 100 MHz clock; all pin timing is counted in its cycles.
package sram_host_pkg;

    localparam int ADDR_W  = 19;
    localparam int DATA_W  = 32;
    localparam int LANES   = 4;
    localparam int LANE_W  = 8;
    localparam int TIMER_W = 4;

    localparam int CLK_PERIOD_NS = 10;

    // Access limits for the two I/O supply options; the slower one is used.
    localparam int ACCESS_MAX_3V3_NS = 20;
    localparam int ACCESS_MAX_2V5_NS = 22;
    localparam int READ_CYCLE_MIN_NS = 22;
    localparam int GATE_ACCESS_MAX_NS = 6;
    localparam int OUTPUT_FLOAT_MAX_NS = 4;

    localparam int WRITE_PULSE_MIN_NS            = 7;
    localparam int SELECT_TO_WRITE_END_NS        = 10;
    localparam int DATA_SETUP_TO_WRITE_END_NS    = 6;
    localparam int ADDRESS_SETUP_TO_WRITE_END_NS = 12;
    localparam int WRITE_RECOVERY_MIN_NS         = 5;
    localparam int WRITE_CYCLE_MIN_NS            = 12;
    localparam int LANE_PULSE_MIN_NS             = 8;

    // Least times round up to whole cycles, never below one.
    function automatic int cycles_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    localparam int READ_ACCESS_CYC = max2(cycles_up(ACCESS_MAX_2V5_NS),
                                          cycles_up(READ_CYCLE_MIN_NS));
    localparam int WRITE_PULSE_CYC = max2(
        max2(cycles_up(WRITE_PULSE_MIN_NS),
             cycles_up(ADDRESS_SETUP_TO_WRITE_END_NS)),
        max2(cycles_up(SELECT_TO_WRITE_END_NS),
             max2(cycles_up(DATA_SETUP_TO_WRITE_END_NS),
                  cycles_up(LANE_PULSE_MIN_NS))));
    localparam int WRITE_RECOVERY_CYC = max2(
        cycles_up(WRITE_RECOVERY_MIN_NS),
        cycles_up(WRITE_CYCLE_MIN_NS) - WRITE_PULSE_CYC);

    localparam logic [TIMER_W-1:0] READ_LOAD =
        TIMER_W'(READ_ACCESS_CYC - 1);
    localparam logic [TIMER_W-1:0] WRITE_LOAD =
        TIMER_W'(WRITE_PULSE_CYC - 1);
    localparam logic [TIMER_W-1:0] RECOVERY_LOAD =
        TIMER_W'(WRITE_RECOVERY_CYC - 1);

    localparam logic [LANES-1:0]  LANES_OFF  = 4'hF;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h00000;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;

endpackage

/* design/sram_op_timer.sv */
// Down-counter that times each phase of a memory access.
// Assumes the controller loads it at the start of every timed phase.
`timescale 1ns/1ps
module sram_op_timer (
    // Clock and reset
    input  wire logic                               mclk,
    input  wire logic                               sys_rst,
    // Load and status
    input  wire logic                               load,
    input  wire logic [sram_host_pkg::TIMER_W-1:0]  loadValue,
    output logic                                    expired
);
    import sram_host_pkg::*;

    typedef struct packed {
        logic [TIMER_W-1:0] count;
    } timer_t;

    timer_t timer_reg;
    timer_t timer_next;

    always_comb
    begin
        timer_next = timer_reg;
        if (load)
        begin
            timer_next.count = loadValue;
        end
        else if (timer_reg.count != '0)
        begin
            timer_next.count = TIMER_W'(timer_reg.count - 1'b1);
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            timer_reg <= '0;
        end
        else
        begin
            timer_reg <= timer_next;
        end
    end

    assign expired = (timer_reg.count == '0);

endmodule

/* design/sram_data_port.sv */
// Data pin stage: drives write data and captures read data per byte lane.
// Assumes the controller keeps drive off whenever the output gate is low.
`timescale 1ns/1ps
module sram_data_port (
    // Clock and reset
    input  wire logic                               mclk,
    input  wire logic                               sys_rst,
    // Control from the sequencer
    input  wire logic                               driveStart,
    input  wire logic                               driveStop,
    input  wire logic                               capture,
    input  wire logic [sram_host_pkg::LANES-1:0]    captureLanes,
    input  wire logic [sram_host_pkg::DATA_W-1:0]   wrData,
    output logic [sram_host_pkg::DATA_W-1:0]        rdData,
    // Data pins
    input  wire logic [sram_host_pkg::DATA_W-1:0]   pinDataIn,
    output logic [sram_host_pkg::DATA_W-1:0]        pinDataOut,
    output logic                                    pinDataOeLow
);
    import sram_host_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] dataOut;
        logic              oeLow;
        logic [DATA_W-1:0] rdData;
    } port_t;

    port_t port_reg;
    port_t port_next;

    always_comb
    begin
        port_next = port_reg;
        if (driveStart)
        begin
            port_next.dataOut = wrData;
            port_next.oeLow   = 1'b0;
        end
        else if (driveStop)
        begin
            port_next.oeLow = 1'b1;
        end
        if (capture)
        begin
            // Disabled lanes float.
            // A lane left out of the read floats, so it returns zero.
            for (int i = 0; i < LANES; i++)
            begin
                port_next.rdData[i*LANE_W +: LANE_W] = captureLanes[i] ?
                    pinDataIn[i*LANE_W +: LANE_W] : '0;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            port_reg <= '{dataOut: DATA_RESET, oeLow: 1'b1,
                          rdData: DATA_RESET};
        end
        else
        begin
            port_reg <= port_next;
        end
    end

    assign pinDataOut   = port_reg.dataOut;
    assign pinDataOeLow = port_reg.oeLow;
    assign rdData       = port_reg.rdData;

endmodule

/* tb/sram_mem_model.sv */
// Behavioural model of the asynchronous word memory behind the host.
// Assumes the bench feeds the resolved wire back to the host's data input.
`timescale 1ns/1ps
module sram_mem_model (
    // Control pins
    input  wire logic [18:0] addr,
    input  wire logic        chipSelectLow,
    input  wire logic        chipEnable,
    input  wire logic        writeStrobeLow,
    input  wire logic        outputGateLow,
    input  wire logic [3:0]  byteLaneEnableLow,
    // Host side of the data wire and answer speed
    input  wire logic [31:0] hostData,
    input  wire logic        hostOeLow,
    input  wire logic [4:0]  accessNs,
    // Resolved wire and host timing faults
    output logic [31:0]      bus,
    output int               faults
);
    logic [31:0] mem [logic [18:0]];
    logic [31:0] shown = 32'h00000000;
    logic [31:0] noise = 32'h5A5A5A5A;
    logic [18:0] wAddr;
    logic        drv;
    logic        wrAct;
    time         stamp = 0;
    time         wStart = 0;
    time         wEnd = 0;
    time         dChange = 0;

    initial faults = 0;
    // A floating wire never shows the last value, so it flickers.
    always #5 noise = ~noise;
    assign wrAct = !chipSelectLow && chipEnable && !writeStrobeLow;
    assign drv = !chipSelectLow && chipEnable && writeStrobeLow
                 && !outputGateLow;
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            bus[8*i+:8] = !hostOeLow ? hostData[8*i+:8]
                        : (drv && !byteLaneEnableLow[i]) ? shown[8*i+:8]
                        : noise[8*i+:8];
    end
    always @(addr or chipSelectLow or chipEnable)
        stamp = $time;
    // Old data held, then invalid until the access ends.
    always #1
    begin
        if ($time - stamp >= accessNs)
            shown = mem.exists(addr) ? mem[addr] : 32'h00000000;
        else if ($time - stamp >= 4)
            shown = noise;
        if (!hostOeLow && drv && byteLaneEnableLow != 4'hF)
            faults++;
    end
    // Lane-wise store. Pins that move in one step update in
    // any order, so the store waits until they have all settled.
    always @(wrAct or addr or hostData or byteLaneEnableLow)
    begin
        #0.5;
        if (wrAct && !mem.exists(addr))
            mem[addr] = 32'h00000000;
        for (int i = 0; i < 4; i++)
            if (wrAct && !byteLaneEnableLow[i])
                mem[addr][8*i+:8] = hostData[8*i+:8];
    end
    always @(hostData)
        dChange = $time;
    always @(posedge wrAct)
    begin
        if (wEnd > 0 && ($time - wEnd < 5 || $time - wStart < 12))
            faults++;
        wStart = $time;
        #1 wAddr = addr;
    end
    always @(negedge wrAct)
        if ($time > 0)
        begin
            if ($time - wStart < 10 || addr != wAddr || $time - dChange < 6)
                faults++;
            wEnd = $time;
        end
    always @(negedge outputGateLow)
        if ($time > 0 && $time - stamp < 1)
            faults++;
endmodule

/* tb/async_sram_word_interface_test.sv */
// Self-checking bench for the host-side memory sequencer.
// Assumes the memory model in tb/ and the shared package are compiled first.
`timescale 1ns/1ps
module async_sram_word_interface_test;
    import sram_host_pkg::*;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        frameWithEnable = 1'b0;
    logic        reqValid = 1'b0;
    logic        reqWrite = 1'b0;
    logic [18:0] reqAddr = 19'h00000;
    logic [31:0] reqWdata = 32'h00000000;
    logic [3:0]  reqLanes = 4'h0;
    logic [4:0]  accessNs = 5'h14;
    logic        reqReady, rspValid, chipSelectLow, chipEnable;
    logic        writeStrobeLow, outputGateLow, dataOeLow;
    logic [31:0] rspRdata, dataIn, dataOut;
    logic [18:0] sramAddr;
    logic [3:0]  byteLaneEnableLow;
    logic [31:0] shadow [logic [18:0]];
    int          faults;
    int          errCount = 0;
    int          checked = 0;
    int          seed = 19;
    logic [31:0] lastWd = 32'h00000000;

    always #5 mclk = ~mclk;

    sram_host_ctrl uut (.mclk(mclk), .sys_rst(sys_rst),
        .frameWithEnable(frameWithEnable), .reqValid(reqValid),
        .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr),
        .reqWdata(reqWdata), .reqLanes(reqLanes), .rspValid(rspValid),
        .rspRdata(rspRdata), .sramAddr(sramAddr),
        .chipSelectLow(chipSelectLow), .chipEnable(chipEnable),
        .writeStrobeLow(writeStrobeLow), .outputGateLow(outputGateLow),
        .byteLaneEnableLow(byteLaneEnableLow), .dataIn(dataIn),
        .dataOut(dataOut), .dataOeLow(dataOeLow));

    sram_mem_model mem (.addr(sramAddr), .chipSelectLow(chipSelectLow),
        .chipEnable(chipEnable), .writeStrobeLow(writeStrobeLow),
        .outputGateLow(outputGateLow), .byteLaneEnableLow(byteLaneEnableLow),
        .hostData(dataOut), .hostOeLow(dataOeLow), .accessNs(accessNs),
        .bus(dataIn), .faults(faults));

    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errCount++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic logic [31:0] expRead(input logic [18:0] a,
                                            input logic [3:0] l);
        logic [31:0] w;
        w = shadow.exists(a) ? shadow[a] : 32'h00000000;
        for (int i = 0; i < 4; i++)
            if (!l[i])
                w[8*i+:8] = 8'h00;
        return w;
    endfunction

    task automatic chkRst;
        @(negedge mclk);
        lastWd = DATA_RESET;
        check({reqReady, rspValid, rspRdata, sramAddr, chipSelectLow,
               chipEnable, writeStrobeLow, outputGateLow, byteLaneEnableLow,
               dataOut, dataOeLow}, {2'b10, DATA_RESET, ADDR_RESET, 4'hF,
               LANES_OFF, DATA_RESET, 1'b1});
    endtask

    task automatic access(input logic wr, input logic [18:0] a,
                          input logic [31:0] d, input logic [3:0] l,
                          input logic fr);
        int n;
        n = 0;
        @(posedge mclk);
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqAddr <= a;
        reqWdata <= d;
        reqLanes <= l;
        frameWithEnable <= fr;
        accessNs <= 5'h06 + 5'($random(seed) & 15);
        @(negedge mclk);
        while (reqReady !== 1'b1 && n < 20)
        begin
            n++;
            @(negedge mclk);
        end
        @(posedge mclk);
        reqValid <= 1'b0;
        n = 0;
        do
        begin
            @(negedge mclk);
            n++;
            if (n == 1)
            begin
                check({sramAddr, byteLaneEnableLow}, {a, ~l});
                check({chipSelectLow, chipEnable}, 2'b01);
                check({outputGateLow, writeStrobeLow}, {1'b1, !wr});
                check({dataOeLow, dataOut}, {!wr, wr ? d : lastWd});
                check(reqReady, 1'b0);
            end
            if (n == 2)
                check(outputGateLow, wr);
        end
        while (rspValid !== 1'b1 && n < 10);
        check(n, 4);
        check({chipSelectLow, chipEnable}, fr ? 2'b00 : 2'b11);
        check({byteLaneEnableLow, dataOeLow}, 5'h1F);
        if (!wr)
            check(rspRdata, expRead(a, l));
        else
        begin
            lastWd = d;
            for (int i = 0; i < 4; i++)
                if (l[i])
                    shadow[a][8*i+:8] = d[8*i+:8];
        end
    endtask

    initial
    begin
        logic [31:0] r;
        for (int i = 0; i < 2; i++)
            shadow[i ? 19'h7FFFF : 19'h00000] = 32'h00000000;
        chkRst;
        repeat (11) @(posedge mclk);
        sys_rst <= 1'b0;
        $display("test reset done");
        // Boundary addresses, both framings, partial and empty lane sets.
        access(1'b1, 19'h00000, 32'h11223344, 4'hF, 1'b0);
        access(1'b1, 19'h7FFFF, 32'hA5A5A5A5, 4'hF, 1'b1);
        access(1'b1, 19'h00000, 32'hFFEEDDCC, 4'h5, 1'b1);
        access(1'b1, 19'h7FFFF, 32'h00000000, 4'h0, 1'b0);
        access(1'b0, 19'h00000, 32'h00000000, 4'hF, 1'b0);
        access(1'b0, 19'h7FFFF, 32'h00000000, 4'hA, 1'b1);
        access(1'b0, 19'h7FFFF, 32'h00000000, 4'h0, 1'b0);
        $display("test corners done");
        for (int k = 0; k < 150; k++)
        begin
            r = $random(seed);
            access(r[0], {r[31], 15'h0000, r[3:1]}, $random(seed),
                   r[7:4], r[8]);
        end
        $display("test random done");
        // A reset that lands in the middle of a read.
        @(posedge mclk);
        reqValid <= 1'b1;
        reqWrite <= 1'b0;
        @(posedge mclk);
        reqValid <= 1'b0;
        @(posedge mclk);
        sys_rst <= 1'b1;
        chkRst;
        @(posedge mclk);
        sys_rst <= 1'b0;
        access(1'b0, 19'h7FFFF, 32'h00000000, 4'hF, 1'b0);
        $display("test mid reset done");
        check(faults, 0);
        end_sim;
    end

    initial
    begin
        #50000;
        errCount++;
        end_sim;
    end
endmodule
